/* sci_exec.sv */
// System-control instruction executor: program counter, return stack,
// working register, global interrupt enable and halt/reset controls.
// Assumes a decoder presents one op per take and other datapath logic
// writes the working register and flags through the side ports.
//
// Function
// RULE_01 - Call pushes pc plus 1, jumps to target, raises stack pointer by 2
// RULE_02 - Absolute jump loads pc with any target in program space
// RULE_03 - Literal return loads working register, then performs plain return
// RULE_04 - Return lowers stack pointer by 2, reloads pc from that slot
// RULE_05 - Interrupt return returns and then sets global enable by itself
// RULE_06 - No op here alters zero, carry, aux-carry or overflow flags; software reset loads them with RST_FLAGS
// RULE_07 - Watchdog clear restarts the watchdog count
// RULE_08 - Relative jump sets pc to pc plus unsigned working register
// RULE_09 - Interrupt-on op sets global enable so requests reach the core
// RULE_10 - Interrupt-off op clears global enable, blocking requests
// RULE_11 - Full halt stops all clocks including oscillators
// RULE_12 - Core halt gates core clock, oscillators keep running
// RULE_13 - Software reset acts exactly like hardware reset
// RULE_14 - Branches and returns take two cycles, others one; software reset here also takes two, halts last until wake
// RULE_15 - Request while enable clear stays pending until enable is set
`default_nettype none

module sci_exec (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic instr_valid, // Decoder offers an op
  input wire logic [3:0] instr_op, // Op code, sci_op_e
  input wire logic [11:0] instr_arg, // Target or literal
  input wire logic acc_we, // Datapath writes working register
  input wire logic [7:0] acc_wdata, // Datapath value for it
  input wire logic flag_we, // Datapath writes flags
  input wire logic [3:0] flag_wdata, // Datapath flag value
  input wire logic irq_req, // Interrupt request level
  input wire logic wake, // Leave either halt
  output logic instr_ready, // Op taken when high with valid
  output logic [11:0] pc, // Program counter
  output logic [7:0] stack_top_ptr, // Stack pointer, byte units
  output logic [7:0] working_register, // Working register
  output logic [3:0] flags, // Z, C, AC, OV
  output logic gie, // Global interrupt enable
  output logic irq_ack, // Interrupt entered, one pulse
  output logic wdt_clear, // Restart watchdog, one pulse
  output logic osc_stop, // Oscillators off
  output logic core_clk_off, // Core clock gated
  output logic chip_reset // Whole-chip reset, one pulse
);

  // ---------------------------------------------------------------
  // State and next values
  // ---------------------------------------------------------------
  sci_pkg::sci_state_e state, next_state;
  logic [11:0] next_pc, push_data, pop_data, pc_inc;
  logic [7:0] next_sp, next_acc, sp_down, arg_lit;
  logic [3:0] next_flags, push_idx, pop_idx;
  logic next_gie, reti_pend, next_reti_pend, take, irq_go, do_reset;
  logic next_ready, irq_seen, next_irq_ack, next_wdt_clear;
  logic next_osc_stop, next_core_clk_off, next_chip_reset, push_en;
  logic [11:0] stack_mem [sci_pkg::STACK_DEPTH];
  sci_pkg::sci_op_e op;
  // Stack slot of an entry is the byte pointer halved
  function automatic logic [3:0] slot_of(input logic [7:0] ptr);
    slot_of = ptr[4:1];
  endfunction
  // Return slot and the entry it holds
  assign sp_down = stack_top_ptr - sci_pkg::SP_STEP;
  assign pop_idx = slot_of(sp_down);
  assign pop_data = stack_mem[pop_idx];
  assign pc_inc = pc + sci_pkg::PC_STEP;
  assign arg_lit = instr_arg[7:0];
  assign op = sci_pkg::sci_op_e'(instr_op);
  // Ready already excludes a waiting interrupt, so no op is lost
  assign irq_go = (state == sci_pkg::ST_RUN) && gie && irq_seen;
  assign take = (state == sci_pkg::ST_RUN) && instr_ready && instr_valid;
  // ---------------------------------------------------------------
  // Sequencer next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_sp = stack_top_ptr;
    next_acc = working_register;
    next_flags = flags;
    next_gie = gie;
    next_reti_pend = reti_pend;
    next_irq_ack = 1'b0;
    next_wdt_clear = 1'b0;
    next_osc_stop = osc_stop;
    next_core_clk_off = core_clk_off;
    next_chip_reset = 1'b0;
    push_en = 1'b0;
    push_idx = slot_of(stack_top_ptr);
    push_data = pc_inc;
    do_reset = 1'b0;
    // Other datapath ops own these; ours write flags only on software reset
    if (acc_we) begin
      next_acc = acc_wdata;
    end
    // RULE_06 flags kept
    if (flag_we) begin
      next_flags = flag_wdata;
    end
    unique case (state)
      sci_pkg::ST_RUN: begin
        if (irq_go) begin
          // Entry saves the address of the op not yet executed
          push_en = 1'b1;
          push_data = pc;
          next_pc = sci_pkg::IRQ_VECTOR;
          next_sp = stack_top_ptr + sci_pkg::SP_STEP;
          next_gie = 1'b0;
          next_irq_ack = 1'b1;
          next_state = sci_pkg::ST_WAIT;
        end else if (take) begin
          next_pc = pc_inc;
          unique case (op)
            // RULE_01 call push
            sci_pkg::OP_CALL: begin
              push_en = 1'b1;
              next_pc = instr_arg;
              next_sp = stack_top_ptr + sci_pkg::SP_STEP;
              next_state = sci_pkg::ST_WAIT;
            end
            // RULE_02 absolute jump
            sci_pkg::OP_JUMP: begin
              next_pc = instr_arg;
              next_state = sci_pkg::ST_WAIT;
            end
            // RULE_03 literal then return
            sci_pkg::OP_RET_LIT: begin
              next_acc = arg_lit;
              next_sp = sp_down;
              next_pc = pop_data;
              next_state = sci_pkg::ST_WAIT;
            end
            // RULE_04 plain return
            sci_pkg::OP_RET: begin
              next_sp = sp_down;
              next_pc = pop_data;
              next_state = sci_pkg::ST_WAIT;
            end
            // RULE_05 return, enable later
            sci_pkg::OP_RET_IRQ: begin
              next_sp = sp_down;
              next_pc = pop_data;
              next_reti_pend = 1'b1;
              next_state = sci_pkg::ST_WAIT;
            end
            // RULE_07 watchdog restart
            sci_pkg::OP_WDT_CLEAR: next_wdt_clear = 1'b1;
            // RULE_08 relative jump, wraps in program space
            sci_pkg::OP_JUMP_REL: begin
              next_pc = pc + {4'h0, working_register};
              next_state = sci_pkg::ST_WAIT;
            end
            // RULE_09 enable on
            sci_pkg::OP_INT_ON: next_gie = 1'b1;
            // RULE_10 enable off
            sci_pkg::OP_INT_OFF: next_gie = 1'b0;
            // RULE_11 stop everything
            sci_pkg::OP_HALT_ALL: begin
              next_osc_stop = 1'b1;
              next_core_clk_off = 1'b1;
              next_state = sci_pkg::ST_HALT_ALL;
            end
            // RULE_12 gate core only
            sci_pkg::OP_HALT_CORE: begin
              next_core_clk_off = 1'b1;
              next_state = sci_pkg::ST_HALT_CORE;
            end
            // RULE_13 same as hardware reset
            sci_pkg::OP_SOFT_RESET: do_reset = 1'b1;
            // No op, other ops and spare codes only step pc
            default: begin
              next_state = sci_pkg::ST_RUN;
            end
          endcase
        end
      end
      // RULE_14 second cycle of two-cycle ops
      sci_pkg::ST_WAIT: begin
        next_state = sci_pkg::ST_RUN;
        // RULE_05 enable once return completes
        if (reti_pend) begin
          next_gie = 1'b1;
          next_reti_pend = 1'b0;
        end
      end
      sci_pkg::ST_HALT_ALL, sci_pkg::ST_HALT_CORE: begin
        if (wake) begin
          next_osc_stop = 1'b0;
          next_core_clk_off = 1'b0;
          next_state = sci_pkg::ST_RUN;
        end
      end
      sci_pkg::ST_RESET: next_state = sci_pkg::ST_RUN;
    endcase
    // RULE_13 reset values everywhere
    if (do_reset) begin
      next_state = sci_pkg::ST_RESET;
      next_pc = sci_pkg::RST_PC;
      next_sp = sci_pkg::RST_SP;
      next_acc = sci_pkg::RST_ACC;
      next_flags = sci_pkg::RST_FLAGS;
      next_gie = sci_pkg::RST_GIE;
      next_reti_pend = 1'b0;
      next_osc_stop = 1'b0;
      next_core_clk_off = 1'b0;
      next_chip_reset = 1'b1;
    end
    // RULE_15 request waits while enable clear
    next_ready = (next_state == sci_pkg::ST_RUN) && !(next_gie && irq_req);
  end
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= sci_pkg::ST_RUN;
      pc <= sci_pkg::RST_PC;
      stack_top_ptr <= sci_pkg::RST_SP;
      working_register <= sci_pkg::RST_ACC;
      flags <= sci_pkg::RST_FLAGS;
      gie <= sci_pkg::RST_GIE;
      reti_pend <= 1'b0;
      instr_ready <= 1'b0;
      irq_seen <= 1'b0;
      irq_ack <= 1'b0;
      wdt_clear <= 1'b0;
      osc_stop <= 1'b0;
      core_clk_off <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      stack_top_ptr <= next_sp;
      working_register <= next_acc;
      flags <= next_flags;
      gie <= next_gie;
      reti_pend <= next_reti_pend;
      instr_ready <= next_ready;
      irq_seen <= irq_req;
      irq_ack <= next_irq_ack;
      wdt_clear <= next_wdt_clear;
      osc_stop <= next_osc_stop;
      core_clk_off <= next_core_clk_off;
      chip_reset <= next_chip_reset;
    end
  end
  // Return stack; contents are undefined after reset, as in RAM
  always_ff @(posedge sys_clk) begin
    if (push_en) begin
      stack_mem[push_idx] <= push_data;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence two_t_seq;
    (state == sci_pkg::ST_WAIT) && !instr_ready ##1 state == sci_pkg::ST_RUN;
  endsequence
  sequence one_t_seq;
    state == sci_pkg::ST_RUN;
  endsequence
  call_push_a: assert property ( // RULE_01
    take && op == sci_pkg::OP_CALL |=> pc == $past(instr_arg) &&
      stack_top_ptr == 8'($past(stack_top_ptr) + 8'h02) &&
      stack_mem[pop_idx] == 12'($past(pc) + 12'h001))
    else $error("call did not push and jump");
  jump_abs_a: assert property ( // RULE_02
    take && op == sci_pkg::OP_JUMP |=> pc == $past(instr_arg) ##1
      state == sci_pkg::ST_RUN)
    else $error("jump target not loaded");
  ret_lit_a: assert property ( // RULE_03
    take && op == sci_pkg::OP_RET_LIT |=>
      working_register == $past(arg_lit) && pc == $past(pop_data))
    else $error("literal return wrong");
  ret_pop_a: assert property ( // RULE_04
    take && op == sci_pkg::OP_RET |=>
      stack_top_ptr == 8'($past(stack_top_ptr) - 8'h02) &&
      pc == $past(pop_data))
    else $error("return did not pop");
  reti_enable_a: assert property ( // RULE_05
    take && op == sci_pkg::OP_RET_IRQ |=> ##1 gie)
    else $error("interrupt return left enable clear");
  flags_keep_a: assert property ( // RULE_06
    take && op != sci_pkg::OP_SOFT_RESET && !flag_we |=>
      flags == $past(flags))
    else $error("flags changed by control op");
  // Back-to-back clears legally keep the pulse high a second cycle
  wdt_pulse_a: assert property ( // RULE_07
    take && op == sci_pkg::OP_WDT_CLEAR |=> wdt_clear ##1
      wdt_clear == $past(take && op == sci_pkg::OP_WDT_CLEAR))
    else $error("watchdog clear pulse wrong");
  jump_rel_a: assert property ( // RULE_08
    take && op == sci_pkg::OP_JUMP_REL |=>
      pc == 12'($past(pc) + {4'h0, $past(working_register)}))
    else $error("relative jump target wrong");
  int_on_a: assert property ( // RULE_09
    take && op == sci_pkg::OP_INT_ON |=> gie)
    else $error("enable not set");
  int_off_a: assert property ( // RULE_10
    take && op == sci_pkg::OP_INT_OFF |=> !gie ##1 !irq_ack)
    else $error("enable not cleared");
  halt_all_a: assert property ( // RULE_11
    take && op == sci_pkg::OP_HALT_ALL |=> osc_stop && core_clk_off &&
      !instr_ready)
    else $error("full halt clocks wrong");
  halt_core_a: assert property ( // RULE_12
    take && op == sci_pkg::OP_HALT_CORE |=> !osc_stop && core_clk_off)
    else $error("core halt clocks wrong");
  soft_reset_a: assert property ( // RULE_13
    take && op == sci_pkg::OP_SOFT_RESET |=> chip_reset &&
      pc == sci_pkg::RST_PC && stack_top_ptr == sci_pkg::RST_SP && !gie)
    else $error("software reset incomplete");
  two_cycle_a: assert property ( // RULE_14
    take && op inside {sci_pkg::OP_CALL, sci_pkg::OP_JUMP,
      sci_pkg::OP_JUMP_REL, sci_pkg::OP_RET, sci_pkg::OP_RET_LIT,
      sci_pkg::OP_RET_IRQ} |=> two_t_seq)
    else $error("branch not two cycles");
  one_cycle_a: assert property ( // RULE_14
    take && op inside {sci_pkg::OP_NO_OP, sci_pkg::OP_WDT_CLEAR,
      sci_pkg::OP_INT_ON, sci_pkg::OP_INT_OFF, sci_pkg::OP_OTHER}
      |=> one_t_seq)
    else $error("simple op not one cycle");
  irq_hold_a: assert property ( // RULE_15
    !gie |=> !irq_ack)
    else $error("interrupt entered while disabled");
  irq_serve_a: assert property ( // RULE_15
    state == sci_pkg::ST_RUN && gie && irq_seen |=> irq_ack &&
      pc == sci_pkg::IRQ_VECTOR && !gie)
    else $error("pending interrupt not served");

endmodule

`default_nettype wire

/* sci_pkg.sv */
// Constants and types for the system-control instruction executor.
// Assumes one clock domain and an external decoder that names the op.
`default_nettype none

package sci_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int SP_W = 8;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 4;
  localparam int STACK_DEPTH = 16;
  localparam int STACK_IDX_W = 4;

  // ---------------------------------------------------------------
  // Flag bit positions (kept untouched by every op here except software reset)
  // ---------------------------------------------------------------
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_CARRY = 1;
  localparam int FLAG_AUX_CARRY = 2;
  localparam int FLAG_OVERFLOW = 3;

  // ---------------------------------------------------------------
  // Reset values and steps
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] RST_PC = 12'h000;
  // Interrupt entry address, plain default
  localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h010;
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  localparam logic [SP_W-1:0] RST_SP = 8'h00;
  localparam logic [SP_W-1:0] SP_STEP = 8'h02;
  localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
  localparam logic RST_GIE = 1'b0;

  // ---------------------------------------------------------------
  // Operation codes from the decoder and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_CALL,
    OP_JUMP,
    OP_RET_LIT,
    OP_RET,
    OP_RET_IRQ,
    OP_NO_OP,
    OP_WDT_CLEAR,
    OP_JUMP_REL,
    OP_INT_ON,
    OP_INT_OFF,
    OP_HALT_ALL,
    OP_HALT_CORE,
    OP_SOFT_RESET
  } sci_op_e;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_HALT_ALL,
    ST_HALT_CORE,
    ST_RESET
  } sci_state_e;

endpackage

`default_nettype wire

/* sci_exec_tb.sv */
// Self-checking bench for the system-control instruction executor.
// Assumes sci_pkg is compiled first; the bench drives every port itself.
`default_nettype none

module sci_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Stimulus rows and bench state
  // ---------------------------------------------------------------
  typedef struct {
    logic [3:0] op;
    logic [11:0] arg;
    logic [11:0] pc;
    logic [7:0] sp;
    logic [7:0] acc;
    logic gie;
  } sci_row_s;

  logic sys_clk, rst_b, instr_valid, acc_we, flag_we, irq_req, wake;
  logic [3:0] instr_op, flag_wdata;
  logic [11:0] instr_arg;
  logic [7:0] acc_wdata;
  logic instr_ready, gie, irq_ack, wdt_clear, osc_stop, core_clk_off;
  logic chip_reset;
  logic [11:0] pc;
  logic [7:0] stack_top_ptr, working_register;
  logic [3:0] flags;
  int fail_count = 0;
  int checks = 0;
  sci_row_s rows[14];

  sci_exec dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_arg(instr_arg), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .flag_we(flag_we), .flag_wdata(flag_wdata),
    .irq_req(irq_req), .wake(wake), .instr_ready(instr_ready), .pc(pc),
    .stack_top_ptr(stack_top_ptr), .working_register(working_register),
    .flags(flags), .gie(gie), .irq_ack(irq_ack), .wdt_clear(wdt_clear),
    .osc_stop(osc_stop), .core_clk_off(core_clk_off),
    .chip_reset(chip_reset)
  );

  // ---------------------------------------------------------------
  // Clock, shared tasks and the single exit
  // ---------------------------------------------------------------
  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Offer an op once ready shows at a falling edge; return one cycle on,
  // with valid still high so 1T ops can run back to back
  task automatic issue(input logic [3:0] op, input logic [11:0] arg);
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 50) begin
      fail_count++;
      wrap_up();
    end
    instr_valid = 1'b1;
    instr_op = op;
    instr_arg = arg;
    @(negedge sys_clk);
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    instr_op = sci_pkg::OP_NO_OP;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic two_t;
    int n;
    rst_b = 1'b0; instr_valid = 1'b0; instr_op = 4'h0; instr_arg = 12'h000;
    acc_we = 1'b0; acc_wdata = 8'h00; flag_we = 1'b0; flag_wdata = 4'h0;
    irq_req = 1'b0; wake = 1'b0;
    rows = '{
      '{sci_pkg::OP_INT_OFF, 12'h000, 12'h001, 8'h00, 8'h3c, 1'b0},
      '{sci_pkg::OP_NO_OP, 12'h000, 12'h002, 8'h00, 8'h3c, 1'b0},
      '{sci_pkg::OP_CALL, 12'h123, 12'h123, 8'h02, 8'h3c, 1'b0},
      '{sci_pkg::OP_CALL, 12'hfff, 12'hfff, 8'h04, 8'h3c, 1'b0},
      '{sci_pkg::OP_RET_LIT, 12'h1a5, 12'h124, 8'h02, 8'ha5, 1'b0},
      '{sci_pkg::OP_JUMP_REL, 12'h000, 12'h1c9, 8'h02, 8'ha5, 1'b0},
      '{sci_pkg::OP_RET, 12'h000, 12'h003, 8'h00, 8'ha5, 1'b0},
      '{sci_pkg::OP_JUMP, 12'h800, 12'h800, 8'h00, 8'ha5, 1'b0},
      '{sci_pkg::OP_WDT_CLEAR, 12'h000, 12'h801, 8'h00, 8'ha5, 1'b0},
      '{sci_pkg::OP_INT_ON, 12'h000, 12'h802, 8'h00, 8'ha5, 1'b1},
      '{sci_pkg::OP_INT_OFF, 12'h000, 12'h803, 8'h00, 8'ha5, 1'b0},
      '{4'he, 12'h000, 12'h804, 8'h00, 8'ha5, 1'b0},
      '{sci_pkg::OP_JUMP, 12'hfa0, 12'hfa0, 8'h00, 8'ha5, 1'b0},
      '{sci_pkg::OP_JUMP_REL, 12'h000, 12'h045, 8'h00, 8'ha5, 1'b0}};
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    // Reset values before any op
    check({pc, stack_top_ptr, working_register}, 28'h0);
    check({flags, gie, instr_ready}, 6'h0);
    acc_we = 1'b1; acc_wdata = 8'h3c; flag_we = 1'b1; flag_wdata = 4'ha;
    @(negedge sys_clk);
    acc_we = 1'b0; flag_we = 1'b0;

    // Table of ordinary ops; flags must survive every one of them
    for (int i = 0; i < 14; i++) begin
      issue(rows[i].op, rows[i].arg);
      two_t = rows[i].op inside {sci_pkg::OP_CALL, sci_pkg::OP_JUMP,
        sci_pkg::OP_JUMP_REL, sci_pkg::OP_RET, sci_pkg::OP_RET_LIT};
      check(pc, rows[i].pc);
      check(stack_top_ptr, rows[i].sp);
      check(working_register, rows[i].acc);
      check(gie, rows[i].gie);
      check(flags, 4'ha);
      check(instr_ready, !two_t);
      check(wdt_clear, rows[i].op == sci_pkg::OP_WDT_CLEAR);
    end
    idle();

    // request held off while enable clear
    irq_req = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({irq_ack, pc}, {1'b0, 12'h045});
    issue(sci_pkg::OP_INT_ON, 12'h000);
    idle();
    check({gie, pc}, {1'b1, 12'h046});
    n = 0;
    while (irq_ack !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    irq_req = 1'b0;
    check(irq_ack, 1'b1);
    check({pc, stack_top_ptr, gie}, {12'h010, 8'h02, 1'b0});
    issue(sci_pkg::OP_RET_IRQ, 12'h000);
    idle();
    check({pc, stack_top_ptr}, {12'h046, 8'h00});
    @(negedge sys_clk);
    check(gie, 1'b1);
    check(flags, 4'ha);

    // both halt kinds, left by wake
    for (int h = 0; h < 2; h++) begin
      issue(h == 0 ? sci_pkg::OP_HALT_ALL : sci_pkg::OP_HALT_CORE, 12'h000);
      idle();
      check(pc, 12'h047 + h);
      repeat (3) @(negedge sys_clk);
      check({osc_stop, core_clk_off}, {h == 0, 1'b1});
      check(instr_ready, 1'b0);
      wake = 1'b1;
      @(negedge sys_clk);
      wake = 1'b0;
      check({osc_stop, core_clk_off}, 2'b00);
      @(negedge sys_clk);
      check(instr_ready, 1'b1);
    end

    // software reset clears like the pin
    issue(sci_pkg::OP_CALL, 12'h2aa);
    idle();
    issue(sci_pkg::OP_SOFT_RESET, 12'h000);
    idle();
    check(chip_reset, 1'b1);
    check({pc, stack_top_ptr, working_register}, 28'h0);
    check({flags, gie, instr_ready}, 6'h0);
    @(negedge sys_clk);
    check({chip_reset, instr_ready}, 2'b01);

    // pin reset in mid-run clears the same state
    acc_we = 1'b1; acc_wdata = 8'h5a; flag_we = 1'b1; flag_wdata = 4'h5;
    issue(sci_pkg::OP_CALL, 12'h155);
    acc_we = 1'b0; flag_we = 1'b0;
    idle();
    check(pc, 12'h155);
    check({stack_top_ptr, working_register}, 16'h025a);
    rst_b = 1'b0;
    @(negedge sys_clk);
    rst_b = 1'b1;
    check({pc, stack_top_ptr, working_register}, 28'h0);
    check({flags, gie, instr_ready, chip_reset}, 7'h0);
    @(negedge sys_clk);
    check(instr_ready, 1'b1);
    wrap_up();
  end
endmodule

`default_nettype wire
